// file: src/demod_tracker.sv
// shared constants and the bit clock recovery tracker
`timescale 1ns/1ps
package demod_pkg;
    localparam int unsigned CLK_HZ      = 200_000_000;
    localparam int unsigned BIT_RATE_HZ = 10_000;
    localparam int unsigned BYTE_TIME_US = 800;
    localparam int unsigned BIT_CYC     = CLK_HZ / BIT_RATE_HZ;
    localparam int unsigned BYTE_BITS   = 8;
    localparam int unsigned CTRL_W      = 5;
    localparam int unsigned CTRL_LOCK_BIT = 0;
    localparam int unsigned CTRL_ON_BIT   = 1;
    localparam int unsigned CTRL_BW_LSB   = 2;
    localparam logic [4:0]  CTRL_RST    = 5'h00;
    localparam logic [7:0]  DATA_RST    = 8'h00;
    localparam logic [2:0]  BW_WIDEST   = 3'h6;
    localparam int unsigned BW_SHIFT_MAX = 7;
endpackage

module demod_tracker
    import demod_pkg::*;
#(
    parameter int unsigned BIT_CYCLES = BIT_CYC
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       enable,
    input  wire logic       lock_sel,
    input  wire logic [2:0] bw_sel,
    input  wire logic       stream,
    output logic            bit_valid,
    output logic            bit_value
);
    localparam int PW = $clog2(BIT_CYCLES + 1);
    localparam logic [PW-1:0] HALF  = PW'(BIT_CYCLES / 2);
    localparam logic [PW-1:0] QTR   = PW'(BIT_CYCLES / 4);
    localparam logic [PW-1:0] THREEQ = PW'((3 * BIT_CYCLES) / 4);
    localparam logic [PW-1:0] LAST  = PW'(BIT_CYCLES - 1);
    localparam logic [PW-1:0] SAT   = PW'(BIT_CYCLES);

    // loop gain doubles per bandwidth step; code 7 is treated as widest
    function automatic int unsigned bw_shift(input logic [2:0] bw);
        logic [2:0] b;
        b = (bw > BW_WIDEST) ? BW_WIDEST : bw;
        return BW_SHIFT_MAX - int'(b);
    endfunction

    logic [PW-1:0] phase_q;
    logic [PW-1:0] since_q;
    logic          prev_q;
    logic          edge_seen;
    logic          free_take;
    logic          pll_take;
    logic [PW-1:0] phase_inc;
    int            err;
    int            corr;

    assign edge_seen = stream ^ prev_q;
    // free mode: a data edge sits half a bit after a midpoint, so it fails
    assign free_take = edge_seen && !lock_sel && (since_q >= THREEQ);
    // pll mode: only edges inside the window around the midpoint count
    assign pll_take  = edge_seen && lock_sel && (phase_q >= QTR)
                       && (phase_q < THREEQ);
    assign phase_inc = (phase_q == LAST) ? '0 : phase_q + 1'b1;
    assign err  = int'(phase_q) - int'(HALF);
    assign corr = err >>> bw_shift(bw_sel);

    always_ff @(posedge clk) begin
        if (rst || !enable) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= stream;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || !enable) begin
            phase_q <= '0;
        end else if (free_take) begin
            phase_q <= HALF;
        end else if (pll_take) begin
            phase_q <= PW'(int'(phase_inc) - corr);
        end else begin
            phase_q <= phase_inc;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || !enable) begin
            since_q <= SAT;
        end else if (free_take || pll_take) begin
            since_q <= '0;
        end else if (since_q != SAT) begin
            since_q <= since_q + 1'b1;
        end
    end

    // sample the first half; positive there means a zero bit
    always_ff @(posedge clk) begin
        if (rst || !enable) begin
            bit_valid <= 1'b0;
            bit_value <= 1'b0;
        end else begin
            bit_valid <= (phase_q == QTR);
            if (phase_q == QTR) begin
                bit_value <= ~stream;
            end
        end
    end

    chk_decode_polarity: assert property (
        @(posedge clk) disable iff (rst)
        (enable && $past(enable) && bit_valid && $past(phase_q) == QTR)
        |-> bit_value == !$past(stream))
        else $error("decoded bit polarity wrong");
    chk_free_realign: assert property (
        @(posedge clk) disable iff (rst)
        (enable && free_take) |=> (!enable || phase_q == HALF))
        else $error("free edge did not realign phase");
    chk_bit_spacing: assert property (
        @(posedge clk) disable iff (rst)
        bit_valid |=> !bit_valid[*8])
        else $error("bits emitted too close together");
endmodule

// file: src/manchester_demod.sv
// manchester data demodulator with two processor ports
`timescale 1ns/1ps
module manchester_demod
    import demod_pkg::*;
#(
    parameter int unsigned BIT_CYCLES = BIT_CYC
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              rx_stream,
    input  wire logic              dsp_ctrl_wr,
    input  wire logic [CTRL_W-1:0] dsp_ctrl_wdata,
    input  wire logic              dsp_data_rd,
    input  wire logic              dsp_irq_clr,
    input  wire logic              mcu_ctrl_wr,
    input  wire logic [CTRL_W-1:0] mcu_ctrl_wdata,
    input  wire logic              mcu_data_rd,
    input  wire logic              mcu_irq_clr,
    output logic      [CTRL_W-1:0] demod_control,
    output logic      [7:0]        demod_byte_data,
    output logic                   dsp_byte_irq,
    output logic                   mcu_byte_irq
);
    logic        sync1_q;
    logic        sync2_q;
    logic        demod_on;
    logic        edge_lock_select;
    logic [2:0]  loop_bw_select;
    logic        bit_valid;
    logic        bit_value;
    logic [6:0]  shift_q;
    logic [2:0]  bit_cnt_q;
    logic        byte_done;

    assign demod_on         = demod_control[CTRL_ON_BIT];
    assign edge_lock_select = demod_control[CTRL_LOCK_BIT];
    assign loop_bw_select   = demod_control[CTRL_BW_LSB +: 3];
    assign byte_done        = demod_on && bit_valid && (bit_cnt_q == 3'h7);

    // the stream comes from the radio, outside this clock
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= rx_stream;
            sync2_q <= sync1_q;
        end
    end

    // both ports share one register; dsp wins a same-cycle collision
    always_ff @(posedge clk) begin
        if (rst) begin
            demod_control <= CTRL_RST;
        end else if (dsp_ctrl_wr) begin
            demod_control <= dsp_ctrl_wdata;
        end else if (mcu_ctrl_wr) begin
            demod_control <= mcu_ctrl_wdata;
        end
    end

    // tracker runs only on the on bit; no receive enable involved
    demod_tracker #(
        .BIT_CYCLES (BIT_CYCLES)
    ) u_tracker (
        .clk        (clk),
        .rst        (rst),
        .enable     (demod_on),
        .lock_sel   (edge_lock_select),
        .bw_sel     (loop_bw_select),
        .stream     (sync2_q),
        .bit_valid  (bit_valid),
        .bit_value  (bit_value)
    );

    // first received bit ends up in the msb
    always_ff @(posedge clk) begin
        if (rst || !demod_on) begin
            shift_q   <= '0;
            bit_cnt_q <= '0;
        end else if (bit_valid) begin
            shift_q   <= {shift_q[5:0], bit_value};
            bit_cnt_q <= bit_cnt_q + 3'h1;
        end
    end

    // an unread byte is simply replaced; there is no overrun flag
    always_ff @(posedge clk) begin
        if (rst) begin
            demod_byte_data <= DATA_RST;
        end else if (byte_done) begin
            demod_byte_data <= {shift_q, bit_value};
        end
    end

    // a new byte beats a clear or read in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            dsp_byte_irq <= 1'b0;
        end else if (byte_done) begin
            dsp_byte_irq <= 1'b1;
        end else if (dsp_data_rd || dsp_irq_clr) begin
            dsp_byte_irq <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mcu_byte_irq <= 1'b0;
        end else if (byte_done) begin
            mcu_byte_irq <= 1'b1;
        end else if (mcu_data_rd || mcu_irq_clr) begin
            mcu_byte_irq <= 1'b0;
        end
    end

    // interrupt checks, per port and for both ports together
    chk_irq_together: assert property (
        @(posedge clk) disable iff (rst)
        byte_done |=> (dsp_byte_irq && mcu_byte_irq))
        else $error("byte interrupts not raised together");
    chk_byte_loaded: assert property (
        @(posedge clk) disable iff (rst)
        byte_done |=> demod_byte_data == {$past(shift_q), $past(bit_value)})
        else $error("data register missed new byte");
    chk_dsp_read_own: assert property (
        @(posedge clk) disable iff (rst)
        (dsp_data_rd && !byte_done && !mcu_data_rd && !mcu_irq_clr)
        |=> (!dsp_byte_irq && mcu_byte_irq == $past(mcu_byte_irq)))
        else $error("dsp read did not clear only its interrupt");
    chk_mcu_read_own: assert property (
        @(posedge clk) disable iff (rst)
        (mcu_data_rd && !byte_done && !dsp_data_rd && !dsp_irq_clr)
        |=> (!mcu_byte_irq && dsp_byte_irq == $past(dsp_byte_irq)))
        else $error("mcu read did not clear only its interrupt");
    chk_clear_bit: assert property (
        @(posedge clk) disable iff (rst)
        ((dsp_irq_clr || mcu_irq_clr) && !byte_done)
        |=> ((!$past(dsp_irq_clr) || !dsp_byte_irq)
             && (!$past(mcu_irq_clr) || !mcu_byte_irq)))
        else $error("clear bit did not drop interrupt");
    chk_dsp_clear_own: assert property (
        @(posedge clk) disable iff (rst)
        (dsp_irq_clr && !byte_done && !mcu_data_rd && !mcu_irq_clr)
        |=> (!dsp_byte_irq && mcu_byte_irq == $past(mcu_byte_irq)))
        else $error("dsp clear touched the other interrupt");
    chk_mcu_clear_own: assert property (
        @(posedge clk) disable iff (rst)
        (mcu_irq_clr && !byte_done && !dsp_data_rd && !dsp_irq_clr)
        |=> (!mcu_byte_irq && dsp_byte_irq == $past(dsp_byte_irq)))
        else $error("mcu clear touched the other interrupt");
    chk_irq_hold: assert property (
        @(posedge clk) disable iff (rst)
        (dsp_byte_irq && !dsp_data_rd && !dsp_irq_clr) |=> dsp_byte_irq)
        else $error("pending interrupt dropped without clear");
    chk_mcu_irq_hold: assert property (
        @(posedge clk) disable iff (rst)
        (mcu_byte_irq && !mcu_data_rd && !mcu_irq_clr) |=> mcu_byte_irq)
        else $error("pending mcu interrupt dropped without clear");
    chk_dsp_no_stray: assert property (
        @(posedge clk) disable iff (rst)
        (!byte_done && !dsp_byte_irq) |=> !dsp_byte_irq)
        else $error("dsp interrupt raised without a byte");
    chk_mcu_no_stray: assert property (
        @(posedge clk) disable iff (rst)
        (!byte_done && !mcu_byte_irq) |=> !mcu_byte_irq)
        else $error("mcu interrupt raised without a byte");

    // register contents and bit assembly
    chk_ctrl_write: assert property (
        @(posedge clk) disable iff (rst)
        (mcu_ctrl_wr && !dsp_ctrl_wr)
        |=> demod_control == $past(mcu_ctrl_wdata))
        else $error("mcu control write lost");
    chk_dsp_ctrl_write: assert property (
        @(posedge clk) disable iff (rst)
        dsp_ctrl_wr |=> demod_control == $past(dsp_ctrl_wdata))
        else $error("dsp control write lost");
    chk_ctrl_stable: assert property (
        @(posedge clk) disable iff (rst)
        (!dsp_ctrl_wr && !mcu_ctrl_wr) |=> $stable(demod_control))
        else $error("control register changed without a write");
    chk_data_stable: assert property (
        @(posedge clk) disable iff (rst)
        !byte_done |=> $stable(demod_byte_data))
        else $error("data register changed without a new byte");
    chk_off_quiet: assert property (
        @(posedge clk) disable iff (rst)
        !demod_on |=> ##1 (!bit_valid && bit_cnt_q == 3'h0))
        else $error("demodulator active while off");
    chk_off_cleared: assert property (
        @(posedge clk) disable iff (rst)
        !demod_on |=> (bit_cnt_q == 3'h0 && shift_q == 7'h00))
        else $error("bit assembly not cleared while off");
    chk_bit_shift: assert property (
        @(posedge clk) disable iff (rst)
        (demod_on && bit_valid)
        |=> (shift_q[0] == $past(bit_value)
             && bit_cnt_q == $past(bit_cnt_q) + 3'h1))
        else $error("decoded bit not shifted in");
endmodule

// file: bench/manchester_source.sv
// manchester coded stream source standing in for the radio receiver
`timescale 1ns/1ps
module manchester_source #(
    parameter real HALF_NS = 100.0
) (
    output logic rx_stream
);
    initial rx_stream = 1'b0;
    // first half carries the inverted bit, so every bit has a midpoint edge
    task automatic send(input logic [7:0] pat, input int nbits);
        for (int i = 0; i < nbits; i++) begin
            rx_stream = ~pat[7 - (i % 8)];
            #(HALF_NS);
            rx_stream = pat[7 - (i % 8)];
            #(HALF_NS);
        end
        // idle low: a leading one bit then starts on a midpoint edge
        rx_stream = 1'b0;
    endtask
endmodule

// file: bench/test_manchester_demod.sv
// self-checking bench for the manchester data demodulator
`timescale 1ns/1ps
module test_manchester_demod;
    import demod_pkg::*;
    localparam int unsigned BC = 40;
    logic              clk;
    logic              rst;
    logic              rx_stream;
    logic [5:0]        strb;
    logic [CTRL_W-1:0] dsp_v;
    logic [CTRL_W-1:0] mcu_v;
    logic [CTRL_W-1:0] demod_control;
    logic [7:0]        demod_byte_data;
    logic [7:0]        first_byte;
    logic              dsp_byte_irq;
    logic              mcu_byte_irq;
    logic              hit;
    int                n_fail = 0;
    int                checks_done = 0;
    int                cyc = 0;
    int                n;
    int                t0;

    manchester_demod #(.BIT_CYCLES(BC)) u_dut (
        .clk            (clk),
        .rst            (rst),
        .rx_stream      (rx_stream),
        .dsp_ctrl_wr    (strb[0]),
        .dsp_ctrl_wdata (dsp_v),
        .dsp_data_rd    (strb[1]),
        .dsp_irq_clr    (strb[2]),
        .mcu_ctrl_wr    (strb[3]),
        .mcu_ctrl_wdata (mcu_v),
        .mcu_data_rd    (strb[4]),
        .mcu_irq_clr    (strb[5]),
        .demod_control  (demod_control),
        .demod_byte_data(demod_byte_data),
        .dsp_byte_irq   (dsp_byte_irq),
        .mcu_byte_irq   (mcu_byte_irq)
    );
    manchester_source #(.HALF_NS(BC * 2.5)) u_src (.rx_stream(rx_stream));

    always #2.5 clk = ~clk;

    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // hang guard, far above the few thousand cycles the tests need
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_fail++;
            final_report();
        end
    end

    task automatic check(input string nm, input logic [7:0] seen,
                         input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one-cycle strobes, results sampled at the following falling edge
    task automatic pulse(input logic [5:0] m);
        @(posedge clk);
        strb <= m;
        @(posedge clk);
        strb <= 6'h00;
        @(negedge clk);
    endtask

    task automatic wait_irq;
        n = 0;
        while (dsp_byte_irq !== 1'b1 && n < 4 * 8 * BC) begin
            @(negedge clk);
            n++;
        end
        check("irq wait", 8'(n < 4 * 8 * BC), 8'h01);
    endtask

    task automatic quiet(input int cycles);
        hit = 1'b0;
        repeat (cycles) begin
            @(negedge clk);
            if (dsp_byte_irq !== 1'b0 || mcu_byte_irq !== 1'b0)
                hit = 1'b1;
        end
    endtask

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        strb = 6'h00;
        dsp_v = 5'h00;
        mcu_v = 5'h00;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check("control", 8'(demod_control), 8'(CTRL_RST));
        check("data", demod_byte_data, DATA_RST);
        check("irqs", 8'({dsp_byte_irq, mcu_byte_irq}), 8'h00);
        // every bandwidth code, ports taking turns
        for (int b = 0; b < 8; b++) begin
            dsp_v <= 5'(b << 2);
            mcu_v <= 5'(b << 2);
            pulse(b[0] ? 6'h08 : 6'h01);
            check("control", 8'(demod_control), 8'(b << 2));
        end
        dsp_v <= 5'h1c;
        mcu_v <= 5'h04;
        pulse(6'h09);
        check("control", 8'(demod_control), 8'h1c);
        // switched off: a running stream must yield no bytes
        fork
            u_src.send(8'h17, 24);
        join_none
        quiet(24 * BC);
        check("off irq", 8'(hit), 8'h00);
        dsp_v <= 5'h1a;
        pulse(6'h01);
        fork
            begin
                #1.3;
                u_src.send(8'hff, 8);
                u_src.send(8'h17, 64);
            end
        join_none
        repeat (2) begin
            wait_irq();
            pulse(6'h24);
        end
        wait_irq();
        t0 = cyc;
        first_byte = demod_byte_data;
        check("irq pair", 8'({dsp_byte_irq, mcu_byte_irq}), 8'h03);
        hit = 1'b0;
        for (int r = 0; r < 8; r++)
            if (first_byte === ((8'h17 << r) | (8'h17 >> (8 - r))))
                hit = 1'b1;
        check("rotation", 8'(hit), 8'h01);
        pulse(6'h02);
        check("irq pair", 8'({dsp_byte_irq, mcu_byte_irq}), 8'h01);
        pulse(6'h20);
        check("irq pair", 8'({dsp_byte_irq, mcu_byte_irq}), 8'h00);
        wait_irq();
        check("byte gap", 8'(cyc - t0 == 8 * BC), 8'h01);
        check("data", demod_byte_data, first_byte);
        // locked mode from the other port, byte left unread
        mcu_v <= 5'h0f;
        pulse(6'h08);
        repeat (8 * BC) @(negedge clk);
        check("irq pair", 8'({dsp_byte_irq, mcu_byte_irq}), 8'h03);
        check("data", demod_byte_data, first_byte);
        pulse(6'h10);
        check("irq pair", 8'({dsp_byte_irq, mcu_byte_irq}), 8'h02);
        check("data", demod_byte_data, first_byte);
        dsp_v <= 5'h18;
        pulse(6'h03);
        quiet(16 * BC);
        check("off irq", 8'(hit), 8'h00);
        final_report();
    end
endmodule
